// ===== bench/ghcs_printer_model.sv
/*
  Listening printer or plotter model on the target link.
  Assumes words arrive as one-cycle tgt_valid pulses on sys_clk.
*/
`timescale 1ns/10ps
module ghcs_printer_model (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        stall,
  input  wire        tgt_valid,
  input  wire [31:0] tgt_data,
  output reg         tgt_ready,
  output reg  [31:0] words_r,
  output reg  [31:0] first_r
);
  // ==========================================================
  // Listen always, no addressing
  always @(posedge sys_clk) begin
    if (rst) begin
      tgt_ready <= 1'b0;
      words_r   <= 32'h0000_0000;
      first_r   <= 32'h0000_0000;
    end else begin
      tgt_ready <= !stall;
      if (tgt_valid) begin
        words_r <= words_r + 1;
        if (words_r == 0)
          first_r <= tgt_data;
      end
    end
  end
endmodule // ghcs_printer_model

// ===== bench/ghcs_properties.sv
/*
  Port checker for the hard-copy sequencer, bound to ghcs_top.
  Assumes sys_clk with synchronous active-high rst.
*/
`timescale 1ns/10ps
module ghcs_properties (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire tgt_valid,
  input wire busy,
  input wire srq,
  input wire err_led,
  input wire centre_req,
  input wire save_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Bus and copy properties
  apb_answer_a: assert property (
    psel && !penable |=> pready) else $error("no zero-wait answer");
  pready_pulse_a: assert property (
    pready |=> !pready) else $error("pready held");
  pready_access_a: assert property (
    pready |-> psel && penable) else $error("pready off access");
  slverr_ready_a: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
  render_first_a: assert property (
    $rose(busy) |-> !tgt_valid [*8]) else $error("word before render");
  word_busy_a: assert property (
    tgt_valid |-> busy) else $error("word sent while idle");
  word_space_a: assert property (
    tgt_valid |=> !tgt_valid) else $error("words back to back");
  srq_done_a: assert property (
    $rose(srq) |-> !busy) else $error("srq during copy");
  err_idle_a: assert property (
    $rose(err_led) |-> !busy) else $error("error while busy");
  centre_first_a: assert property (
    centre_req |-> !save_mode) else $error("centre after save");
endmodule // ghcs_properties

bind ghcs_top ghcs_properties chk_i (
  .sys_clk    (sys_clk),
  .rst        (rst),
  .psel       (psel),
  .penable    (penable),
  .pready     (pready),
  .pslverr    (pslverr),
  .tgt_valid  (tgt_valid),
  .busy       (busy),
  .srq        (srq),
  .err_led    (err_led),
  .centre_req (centre_req),
  .save_mode  (save_mode)
);

// ===== bench/gpib_hardcopy_sequencer_bench.sv
/*
  Self-checking bench: APB tasks drive copy scenarios.
  Assumes ghcs_top, the map header and the printer model.
*/
`timescale 1ns/10ps
`include "ghcs_map.vh"
module gpib_hardcopy_sequencer_bench;
  reg         sys_clk = 0;
  reg         rst = 1;
  reg         psel = 0;
  reg         penable = 0;
  reg         pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0;
  reg         panel_key = 0;
  reg         delta_event = 0;
  reg         tgt_present = 1;
  reg         stall = 0;
  wire [31:0] prdata, tgt_data, time_stamp, words_r, first_r;
  wire        pready, pslverr, tgt_ready, tgt_valid, busy, srq;
  wire        addr_led, err_led, centre_req, save_mode;
  reg  [31:0] rd, base;
  reg         er;
  integer     miscompares = 0;
  integer     checks_done = 0;
  integer     cseen = 0;
  integer     i;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (centre_req === 1'b1) cseen = cseen + 1;

  ghcs_top uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .panel_key, .delta_event,
    .tgt_present, .tgt_ready, .tgt_data, .tgt_valid, .busy, .srq,
    .addr_led, .err_led, .centre_req, .save_mode, .time_stamp);
  ghcs_printer_model pm (.sys_clk, .rst, .stall, .tgt_valid,
    .tgt_data, .tgt_ready, .words_r, .first_r);

  // ==========================================================
  // Tasks
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wt(input string nm, input v);
    integer n;
    n = 0;
    while (busy !== v && n < 600) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    chk(nm, v, busy);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    apb(0, `GHCS_STATUS_OFS, 0);
    chk("status rst", 0, rd);
    apb(0, `GHCS_COMPOSE_OFS, 0);
    chk("compose rst", `GHCS_COMPOSE_RESET, rd);
    apb(0, 12'h100, 0);
    chk("slverr", 1, er);
    for (i = 0; i < 2; i = i + 1) begin
      apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0008 << i);
      apb(0, `GHCS_STATUS_OFS, 0);
      chk("format", i, rd[`GHCS_ST_FMT]);
    end
    apb(1, `GHCS_CTRL_OFS, 32'h0000_0006);
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0001);
    apb(0, `GHCS_STATUS_OFS, 0);
    chk("armed", 32'h0000_0002, rd[1:0]);
    stall <= 1;
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0002);
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0001);
    repeat (40) @(posedge sys_clk);
    chk("stalled", 0, words_r);
    stall <= 0;
    wt("bus copy", 0);
    chk("words", 8, words_r);
    chk("first", 32'h8A01_0000, first_r);
    chk("srq", 1, srq);
    apb(0, `GHCS_EVENT_OFS, 0);
    chk("event", 463, rd);
    @(posedge sys_clk);
    chk("srq clr", 0, srq);
    apb(0, `GHCS_STATUS_OFS, 0);
    chk("rearm", 0, rd[`GHCS_ST_ARMED]);
    apb(1, `GHCS_CTRL_OFS, 32'h0000_0036);
    apb(1, `GHCS_COMPOSE_OFS, 32'h0000_000F);
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0001);
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0002);
    base = words_r;
    wt("dcl start", 1);
    repeat (20) @(posedge sys_clk);
    apb(1, `GHCS_BUSCMD_OFS, 32'h0000_0004);
    repeat (2) @(posedge sys_clk);
    chk("dcl", 0, busy);
    chk("dcl part", 1, words_r - base < 16);
    chk("dcl sent", 1, words_r - base > 0);
    chk("content", 8'hBF, tgt_data[31:24]);
    apb(1, `GHCS_CTRL_OFS, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk("addr led", 1, addr_led);
    panel_key <= 1;
    wt("key start", 1);
    panel_key <= 0;
    repeat (8) @(posedge sys_clk);
    panel_key <= 1;
    repeat (6) @(posedge sys_clk);
    chk("key abort", 0, busy);
    panel_key <= 0;
    tgt_present <= 0;
    repeat (6) @(posedge sys_clk);
    panel_key <= 1;
    repeat (40) @(posedge sys_clk);
    chk("no target", 1, err_led);
    chk("no target", 0, busy);
    panel_key <= 0;
    tgt_present <= 1;
    apb(1, `GHCS_CTRL_OFS, 32'h0000_000D);
    repeat (6) @(posedge sys_clk);
    delta_event <= 1;
    wt("delta start", 1);
    chk("centre", 1, cseen);
    wt("delta end", 0);
    repeat (4) @(posedge sys_clk);
    chk("delta srq", 0, srq);
    chk("stamp", 1, time_stamp != 0);
    chk("delta err", 0, err_led);
    report_and_stop;
  end

  initial begin
    #(4 * 20000);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // gpib_hardcopy_sequencer_bench

// ===== hw/ghcs_map.vh
/*
  Register map, field positions, reset values and codes of the hard-copy
  sequencer. Assumes a 32-bit APB register bus with byte addressing.
*/
`ifndef GHCS_MAP_VH
`define GHCS_MAP_VH

// ==========================================================
// Register byte offsets
`define GHCS_CTRL_OFS      12'h000
`define GHCS_COMPOSE_OFS   12'h004
`define GHCS_BUSCMD_OFS    12'h008
`define GHCS_STATUS_OFS    12'h00C
`define GHCS_EVENT_OFS     12'h010
`define GHCS_DATA_OFS      12'h014

// ==========================================================
// Control fields
`define GHCS_CTRL_TALK_ONLY   0
`define GHCS_CTRL_FMT         1
`define GHCS_CTRL_DONE_EN     2
`define GHCS_CTRL_DELTA_EN    3
`define GHCS_CTRL_CTL_CONTENT 5:4
`define GHCS_CTRL_RESET       32'h0000_0000

// Compose fields
`define GHCS_CMP_SETTINGS  0
`define GHCS_CMP_GRAT      1
`define GHCS_CMP_TEXT      2
`define GHCS_CMP_WAVE      3
`define GHCS_COMPOSE_RESET 32'h0000_000A

// Bus command strobes (write-one pulses)
`define GHCS_CMD_PRINT     0
`define GHCS_CMD_TALK      1
`define GHCS_CMD_DCL       2
`define GHCS_CMD_DEV_PLOT  3
`define GHCS_CMD_DEV_INK   4

// Status fields
`define GHCS_ST_BUSY       0
`define GHCS_ST_ARMED      1
`define GHCS_ST_ERROR      2
`define GHCS_ST_ADDR_LED   3
`define GHCS_ST_SRQ        4
`define GHCS_ST_FMT        5

// Event code and timing
`define GHCS_EVT_DONE      16'h01CF
`define GHCS_RENDER_CYC    8'h10
`define GHCS_ELEM_WORDS    8'h04
`define GHCS_TGT_TIMEOUT   16'h0400

`endif

// ===== hw/ghcs_render.v
/*
  Screen renderer: times a fixed render count of GHCS_RENDER_CYC cycles.
  Assumes start pulses only while idle; done pulses one cycle.
*/
`timescale 1ns/10ps
`include "ghcs_map.vh"
module ghcs_render (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       start,
  input  wire       abort,
  output reg        done_r
);
  reg [7:0] cnt_r;
  reg       run_r;

  // ==========================================================
  // Render timer
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_r  <= 8'h00;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        run_r <= 1'b0;
      end else if (start) begin
        run_r <= 1'b1;
        cnt_r <= `GHCS_RENDER_CYC;
      end else if (run_r) begin
        if (cnt_r == 8'h01) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // ghcs_render

// ===== hw/ghcs_sync.v
/*
  Two flip-flop synchroniser for one asynchronous level.
  Assumes the input comes from a pin outside sys_clk's domain.
*/
`timescale 1ns/10ps
module ghcs_sync (
  input  wire sys_clk,
  input  wire rst,
  input  wire din,
  output wire dout
);
  reg meta_r;
  reg sync_r;

  // ==========================================================
  // Two stages
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule // ghcs_sync

// ===== hw/ghcs_top.v
/*
  Hard-copy sequencer: accepts print requests, renders, streams words
  to a listening printer or plotter, reports busy and completion.
  Assumes an APB master on sys_clk and asynchronous panel/link pins.
*/
// How it works
// - Render screen first, then transmit it
// - Panel key (talk-only mode) or bus print command
// - Talk-only mode lights address indicator
// - Two formats, chosen locally or by command
// - Start key aborts a running copy in talk-only mode
// - Misconfigured or missing target flags error
// - Controller mode allows extra content screens
// - Bus print arms; talk address sends
// - Send only selected copy elements
// - Completion of a key or bus copy raises SRQ with code 463
// - Busy bit set throughout the copy
// - Device clear aborts a running copy
// - Centre delta event before save mode
// - Delta event: copy, time-stamp, rearm
`timescale 1ns/10ps
`include "ghcs_map.vh"
module ghcs_top (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        panel_key,
  input  wire        delta_event,
  input  wire        tgt_present,
  input  wire        tgt_ready,
  output reg  [31:0] tgt_data,
  output reg         tgt_valid,
  output reg         busy,
  output reg         srq,
  output reg         addr_led,
  output reg         err_led,
  output reg         centre_req,
  output reg         save_mode,
  output reg  [31:0] time_stamp
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_ARMED  = 3'h1;
  localparam ST_RENDER = 3'h2;
  localparam ST_SEND   = 3'h3;
  localparam ST_CENTRE = 3'h4;
  localparam ST_STAMP  = 3'h5;
  localparam [31:0] CMP_RST = `GHCS_COMPOSE_RESET;

  reg  [31:0] ctrl_r;
  reg  [3:0]  compose_r;
  reg  [2:0]  st_r;
  reg  [2:0]  elem_r;
  reg  [7:0]  word_r;
  reg  [15:0] wait_r;
  reg  [15:0] event_r;
  reg  [31:0] tick_r;
  reg         key_d_r;
  reg         delta_d_r;
  reg         from_delta_r;
  reg         render_go_r;
  reg         abort_r;
  wire        key_s;
  wire        delta_s;
  wire        pres_s;
  wire        rdy_s;
  wire        render_done;
  wire        wr_acc;
  wire        key_edge;
  wire        delta_edge;
  wire        cmd_wr;
  wire        talk_only;

  // ==========================================================
  // Pin synchronisers
  ghcs_sync u_key   (.sys_clk(sys_clk), .rst(rst), .din(panel_key),
                     .dout(key_s));
  ghcs_sync u_delta (.sys_clk(sys_clk), .rst(rst), .din(delta_event),
                     .dout(delta_s));
  ghcs_sync u_pres  (.sys_clk(sys_clk), .rst(rst), .din(tgt_present),
                     .dout(pres_s));
  ghcs_sync u_rdy   (.sys_clk(sys_clk), .rst(rst), .din(tgt_ready),
                     .dout(rdy_s));

  ghcs_render u_render (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (render_go_r),
    .abort   (abort_r),
    .done_r  (render_done)
  );

  assign wr_acc     = psel & penable & pwrite;
  assign cmd_wr     = wr_acc & (paddr == `GHCS_BUSCMD_OFS);
  assign key_edge   = key_s & ~key_d_r;
  assign delta_edge = delta_s & ~delta_d_r;
  assign talk_only  = ctrl_r[`GHCS_CTRL_TALK_ONLY];

  // ==========================================================
  // APB slave, one wait-free access
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable) begin
        if (paddr == `GHCS_CTRL_OFS) begin
          prdata <= ctrl_r;
        end else if (paddr == `GHCS_COMPOSE_OFS) begin
          prdata <= {28'h000_0000, compose_r};
        end else if (paddr == `GHCS_BUSCMD_OFS) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == `GHCS_STATUS_OFS) begin
          prdata <= {26'h000_0000, ctrl_r[`GHCS_CTRL_FMT], srq,
                     addr_led, err_led, st_r == ST_ARMED, busy};
        end else if (paddr == `GHCS_EVENT_OFS) begin
          prdata <= {16'h0000, event_r};
        end else if (paddr == `GHCS_DATA_OFS) begin
          prdata <= tick_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Control and compose registers
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= `GHCS_CTRL_RESET;
      compose_r <= CMP_RST[3:0];
    end else if (psel & penable & pready & pwrite) begin
      if (paddr == `GHCS_CTRL_OFS) begin
        ctrl_r <= {26'h000_0000, pwdata[5:0]};
      end else if (paddr == `GHCS_COMPOSE_OFS) begin
        compose_r <= pwdata[3:0];
      end else if (paddr == `GHCS_BUSCMD_OFS) begin
        if (pwdata[`GHCS_CMD_DEV_PLOT])
          ctrl_r[`GHCS_CTRL_FMT] <= 1'b0;
        else if (pwdata[`GHCS_CMD_DEV_INK])
          ctrl_r[`GHCS_CTRL_FMT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Copy sequencer
  always @(posedge sys_clk) begin
    if (rst) begin
      st_r         <= ST_IDLE;
      key_d_r      <= 1'b0;
      delta_d_r    <= 1'b0;
      from_delta_r <= 1'b0;
      render_go_r  <= 1'b0;
      abort_r      <= 1'b0;
      elem_r       <= 3'd0;
      word_r       <= 8'h00;
      wait_r       <= 16'h0000;
      event_r      <= 16'h0000;
      tick_r       <= 32'h0000_0000;
      tgt_data     <= 32'h0000_0000;
      tgt_valid    <= 1'b0;
      busy         <= 1'b0;
      srq          <= 1'b0;
      addr_led     <= 1'b0;
      err_led      <= 1'b0;
      centre_req   <= 1'b0;
      save_mode    <= 1'b0;
      time_stamp   <= 32'h0000_0000;
    end else begin
      key_d_r     <= key_s;
      delta_d_r   <= delta_s;
      tick_r      <= tick_r + 32'h0000_0001;
      render_go_r <= 1'b0;
      abort_r     <= 1'b0;
      centre_req  <= 1'b0;
      addr_led    <= talk_only;
      if (psel & penable & pready & ~pwrite &
          (paddr == `GHCS_EVENT_OFS))
        srq <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (talk_only & ctrl_r[`GHCS_CTRL_DELTA_EN] & delta_edge) begin
            st_r         <= ST_CENTRE;
            centre_req   <= 1'b1;
            from_delta_r <= 1'b1;
          end else if (key_edge | (cmd_wr & pwdata[`GHCS_CMD_PRINT])) begin
            if (key_edge & talk_only) begin
              st_r         <= ST_RENDER;
              render_go_r  <= 1'b1;
              busy         <= 1'b1;
              err_led      <= 1'b0;
              from_delta_r <= 1'b0;
            end else if (~key_edge) begin
              st_r <= ST_ARMED;
            end
          end
        end
        ST_ARMED: begin
          if (cmd_wr & pwdata[`GHCS_CMD_DCL]) begin
            st_r <= ST_IDLE;
          end else if (cmd_wr & pwdata[`GHCS_CMD_TALK]) begin
            st_r         <= ST_RENDER;
            render_go_r  <= 1'b1;
            busy         <= 1'b1;
            err_led      <= 1'b0;
            from_delta_r <= 1'b0;
          end
        end
        ST_CENTRE: begin
          save_mode   <= 1'b1;
          err_led     <= 1'b0;
          st_r        <= ST_RENDER;
          render_go_r <= 1'b1;
          busy        <= 1'b1;
        end
        ST_RENDER: begin
          if (render_done) begin
            st_r   <= ST_SEND;
            elem_r <= 3'd0;
            word_r <= 8'h00;
            wait_r <= 16'h0000;
          end
        end
        ST_SEND: begin
          tgt_valid <= 1'b0;
          if (elem_r == 3'd4) begin
            st_r <= from_delta_r ? ST_STAMP : ST_IDLE;
            busy <= from_delta_r;
            if (~from_delta_r & ctrl_r[`GHCS_CTRL_DONE_EN]) begin
              srq     <= 1'b1;
              event_r <= `GHCS_EVT_DONE;
            end
          end else if (~compose_r[elem_r[1:0]]) begin
            elem_r <= elem_r + 3'd1;
          end else if (~pres_s | (wait_r == `GHCS_TGT_TIMEOUT)) begin
            err_led   <= 1'b1;
            st_r      <= ST_IDLE;
            busy      <= 1'b0;
            save_mode <= 1'b0;
          end else if (rdy_s & ~tgt_valid) begin
            tgt_valid <= 1'b1;
            tgt_data  <= {ctrl_r[`GHCS_CTRL_FMT], 1'b0, ctrl_r[5:4],
                          compose_r, 5'h00, elem_r, 8'h00, word_r};
            wait_r    <= 16'h0000;
            if (word_r == `GHCS_ELEM_WORDS - 8'h01) begin
              word_r <= 8'h00;
              elem_r <= elem_r + 3'd1;
            end else begin
              word_r <= word_r + 8'h01;
            end
          end else begin
            wait_r <= wait_r + 16'h0001;
          end
        end
        ST_STAMP: begin
          time_stamp <= tick_r;
          save_mode  <= 1'b0;
          busy       <= 1'b0;
          st_r       <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
      if (busy & (st_r == ST_RENDER | st_r == ST_SEND) &
          ((key_edge & talk_only) | (cmd_wr & pwdata[`GHCS_CMD_DCL]))) begin
        st_r      <= ST_IDLE;
        abort_r   <= 1'b1;
        busy      <= 1'b0;
        tgt_valid <= 1'b0;
        save_mode <= 1'b0;
      end
    end
  end
endmodule // ghcs_top
